// ===== hdl/ehci_cmd_pkg.sv
// Constants of the command register block; its threshold timer takes its interval through a port
package ehci_cmd_pkg;
   // Register placement and field layout
   localparam logic [7:0] CMD_OFFSET = 8'h20;
   localparam int THR_LSB = 16;
   localparam int THR_MSB = 23;
   localparam int LIGHT_RESET_BIT = 7;
   localparam int DOORBELL_BIT = 6;
   localparam int ASYNC_EN_BIT = 5;
   localparam int THR_BYTE = 2;
   localparam int LOW_BYTE = 0;
   // Values after reset
   localparam logic [7:0] THR_RESET = 8'h08;
   localparam logic ASYNC_EN_RESET = 1'b0;
   localparam logic DOORBELL_RESET = 1'b0;
   // Threshold encodings
   localparam logic [7:0] THR_1 = 8'h01;
   localparam logic [7:0] THR_2 = 8'h02;
   localparam logic [7:0] THR_4 = 8'h04;
   localparam logic [7:0] THR_8 = 8'h08;
   localparam logic [7:0] THR_16 = 8'h10;
   localparam logic [7:0] THR_32 = 8'h20;
   localparam logic [7:0] THR_64 = 8'h40;
   // Interval lengths in microframes
   localparam logic [6:0] MF_1 = 7'h01;
   localparam logic [6:0] MF_2 = 7'h02;
   localparam logic [6:0] MF_4 = 7'h04;
   localparam logic [6:0] MF_8 = 7'h08;
   localparam logic [6:0] MF_16 = 7'h10;
   localparam logic [6:0] MF_32 = 7'h20;
   localparam logic [6:0] MF_64 = 7'h40;
   // Microframe timing
   localparam int MICROFRAME_NS = 125000;
   localparam int CLK_PERIOD_NS = 10;
   localparam int MICROFRAME_CYCLES = MICROFRAME_NS / CLK_PERIOD_NS;
   localparam int MF_CNT_W = 14;
   // Light reset sequencer
   typedef enum logic [0:0] {LR_IDLE, LR_BUSY} light_state_t;
endpackage : ehci_cmd_pkg

// ===== hdl/threshold_timer.sv
// Holds interrupt events and releases them on threshold boundaries
`timescale 1ns/1ps
module threshold_timer (
   input wire logic clk, // Controller clock
   input wire logic reset, // Asynchronous, active high
   input wire logic restart, // Restart interval, drop pending events
   input wire logic mf_tick, // One pulse per microframe
   input wire logic [6:0] interval, // Interval length in microframes
   input wire logic event_in, // Interrupt event, pulse or level
   output logic fire_q // One-cycle interrupt at a boundary
);
   logic [6:0] mf_cnt_q, mf_cnt_d;
   logic pending_q, pending_d;
   logic fire_d;
   logic boundary;

   // Boundary once the chosen number of microframes has passed
   assign boundary = mf_tick && ((mf_cnt_q + 7'h01) >= interval);

   // Count microframes and hold events until the boundary
   always_comb begin
      mf_cnt_d = mf_cnt_q;
      pending_d = pending_q || event_in;
      fire_d = 1'b0;
      if (restart) begin
         mf_cnt_d = 7'h00;
         pending_d = 1'b0;
      end else if (boundary) begin
         mf_cnt_d = 7'h00;
         fire_d = pending_q || event_in;
         pending_d = 1'b0;
      end else if (mf_tick) begin
         mf_cnt_d = mf_cnt_q + 7'h01;
      end
   end

   // State registers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         mf_cnt_q <= 7'h00;
         pending_q <= 1'b0;
         fire_q <= 1'b0;
      end else begin
         mf_cnt_q <= mf_cnt_d;
         pending_q <= pending_d;
         fire_q <= fire_d;
      end
   end
endmodule : threshold_timer

// ===== hdl/ehci_command_control.sv
// Command register of the high-speed host controller: threshold, light reset, doorbell, async enable
`timescale 1ns/1ps
module ehci_command_control #(
   parameter bit LIGHT_RESET_IMPL = 1'b1, // Light reset feature present
   parameter int MF_CYCLES = ehci_cmd_pkg::MICROFRAME_CYCLES // Clock cycles per microframe
) (
   input wire logic clk, // Controller clock, 100 MHz
   input wire logic reset, // Asynchronous, active high
   input wire logic [7:0] addr, // Byte offset in operational space
   input wire logic wr_en, // Write strobe, one cycle
   input wire logic [3:0] byte_en, // Write byte enables
   input wire logic [31:0] wdata, // Write data
   input wire logic rd_en, // Read strobe, one cycle
   output logic [31:0] rdata, // Read data, valid with rd_valid
   output logic rd_valid, // Read answer pulse
   input wire logic controller_halted_flag, // Controller halted status
   input wire logic cache_evicted, // Schedule engine dropped cached state
   input wire logic async_advance_flag_clear, // Status write-one-to-clear of the flag
   input wire logic async_advance_irq_enable, // Interrupt enable for the flag
   input wire logic other_irq_event, // Other interrupt causes of the core
   input wire logic light_reset_done, // Core finished its light reset
   output logic async_advance_doorbell, // Doorbell waiting for the engine
   output logic async_advance_flag, // Async advance status flag
   output logic async_schedule_enable, // Process the async schedule
   output logic async_list_fetch_enable, // Fetch through the list address register
   output logic core_light_reset, // Light reset held on the core
   output logic [7:0] interrupt_threshold_field, // Current threshold value
   output logic irq_issue // Interrupt pulse at a threshold boundary
);
   logic [7:0] thr_q, thr_d;
   logic aen_q, aen_d;
   logic bell_q, bell_d;
   logic flag_q, flag_d;
   logic fetch_q, fetch_d;
   logic [31:0] rdata_q, rdata_d;
   logic rvalid_q, rvalid_d;
   logic [ehci_cmd_pkg::MF_CNT_W-1:0] div_q, div_d;
   logic mf_tick;
   ehci_cmd_pkg::light_state_t lr_q, lr_d;
   logic lr_active;
   logic cmd_wr;
   logic flag_set;
   logic [6:0] interval;

   assign cmd_wr = wr_en && (addr == ehci_cmd_pkg::CMD_OFFSET);
   assign lr_active = (lr_q == ehci_cmd_pkg::LR_BUSY);
   // An eviction during light reset is dropped, so the flag really comes back cleared
   assign flag_set = bell_q && cache_evicted && !lr_active;

   // Threshold encoding to interval length; invalid codes fall back to one microframe
   always_comb begin
      case (thr_q)
         ehci_cmd_pkg::THR_1: interval = ehci_cmd_pkg::MF_1;
         ehci_cmd_pkg::THR_2: interval = ehci_cmd_pkg::MF_2;
         ehci_cmd_pkg::THR_4: interval = ehci_cmd_pkg::MF_4;
         ehci_cmd_pkg::THR_8: interval = ehci_cmd_pkg::MF_8;
         ehci_cmd_pkg::THR_16: interval = ehci_cmd_pkg::MF_16;
         ehci_cmd_pkg::THR_32: interval = ehci_cmd_pkg::MF_32;
         ehci_cmd_pkg::THR_64: interval = ehci_cmd_pkg::MF_64;
         default: interval = ehci_cmd_pkg::MF_1;
      endcase
   end

   // Light reset sequencer: held until the core reports completion
   always_comb begin
      lr_d = lr_q;
      case (lr_q)
         ehci_cmd_pkg::LR_IDLE: begin
            if (LIGHT_RESET_IMPL && cmd_wr && byte_en[ehci_cmd_pkg::LOW_BYTE] &&
                  wdata[ehci_cmd_pkg::LIGHT_RESET_BIT]) begin
               lr_d = ehci_cmd_pkg::LR_BUSY;
            end
         end
         ehci_cmd_pkg::LR_BUSY: begin
            if (light_reset_done) begin
               lr_d = ehci_cmd_pkg::LR_IDLE;
            end
         end
         default: lr_d = ehci_cmd_pkg::LR_IDLE;
      endcase
   end

   // Command fields; writes are dropped while a light reset runs
   always_comb begin
      thr_d = thr_q;
      aen_d = aen_q;
      bell_d = bell_q;
      if (lr_active) begin
         // Core state back to defaults; port state lives elsewhere and is untouched
         thr_d = ehci_cmd_pkg::THR_RESET;
         aen_d = ehci_cmd_pkg::ASYNC_EN_RESET;
         bell_d = ehci_cmd_pkg::DOORBELL_RESET;
      end else begin
         if (cmd_wr && byte_en[ehci_cmd_pkg::THR_BYTE]) begin
            // Taken even when running; results then are the writer's problem
            thr_d = wdata[ehci_cmd_pkg::THR_MSB:ehci_cmd_pkg::THR_LSB];
         end
         if (cmd_wr && byte_en[ehci_cmd_pkg::LOW_BYTE]) begin
            aen_d = wdata[ehci_cmd_pkg::ASYNC_EN_BIT];
         end
         if (flag_set) begin
            bell_d = 1'b0;
         end
         // Writing zero never cancels a rung doorbell
         if (cmd_wr && byte_en[ehci_cmd_pkg::LOW_BYTE] && wdata[ehci_cmd_pkg::DOORBELL_BIT]) begin
            bell_d = 1'b1;
         end
      end
   end

   // Status flag: a set in the clearing cycle wins
   always_comb begin
      flag_d = flag_q;
      if (async_advance_flag_clear || lr_active) begin
         flag_d = 1'b0;
      end
      if (flag_set) begin
         flag_d = 1'b1;
      end
      fetch_d = aen_q && !controller_halted_flag && !lr_active;
   end

   // Register read port, one cycle latency; other offsets read zero
   always_comb begin
      rdata_d = rdata_q;
      rvalid_d = rd_en;
      if (rd_en) begin
         rdata_d = 32'h0000_0000;
         if (addr == ehci_cmd_pkg::CMD_OFFSET) begin
            rdata_d[ehci_cmd_pkg::THR_MSB:ehci_cmd_pkg::THR_LSB] = thr_q;
            rdata_d[ehci_cmd_pkg::LIGHT_RESET_BIT] = LIGHT_RESET_IMPL && lr_active;
            rdata_d[ehci_cmd_pkg::DOORBELL_BIT] = bell_q;
            rdata_d[ehci_cmd_pkg::ASYNC_EN_BIT] = aen_q;
         end
      end
   end

   // Microframe divider, restarted by light reset so boundaries realign
   always_comb begin
      div_d = div_q + 1'b1;
      if (lr_active || (div_q == ehci_cmd_pkg::MF_CNT_W'(MF_CYCLES - 1))) begin
         div_d = '0;
      end
   end
   assign mf_tick = !lr_active && (div_q == ehci_cmd_pkg::MF_CNT_W'(MF_CYCLES - 1));

   // Light reset sequencer state
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         lr_q <= ehci_cmd_pkg::LR_IDLE;
      end else begin
         lr_q <= lr_d;
      end
   end

   // Command fields
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         thr_q <= ehci_cmd_pkg::THR_RESET;
         aen_q <= ehci_cmd_pkg::ASYNC_EN_RESET;
         bell_q <= ehci_cmd_pkg::DOORBELL_RESET;
      end else begin
         thr_q <= thr_d;
         aen_q <= aen_d;
         bell_q <= bell_d;
      end
   end

   // Status flag and list fetch gate
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         flag_q <= 1'b0;
         fetch_q <= 1'b0;
      end else begin
         flag_q <= flag_d;
         fetch_q <= fetch_d;
      end
   end

   // Read port; data holds between reads so a slow reader still sees it
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rdata_q <= 32'h0000_0000;
         rvalid_q <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
      end
   end

   // Microframe divider
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         div_q <= '0;
      end else begin
         div_q <= div_d;
      end
   end

   // Interrupt moderation; the flag counts as an event only when enabled
   threshold_timer u_threshold_timer (
      .clk(clk),
      .reset(reset),
      .restart(lr_active),
      .mf_tick(mf_tick),
      .interval(interval),
      .event_in(other_irq_event || (flag_set && async_advance_irq_enable)),
      .fire_q(irq_issue)
   );

   assign rdata = rdata_q;
   assign rd_valid = rvalid_q;
   assign async_advance_doorbell = bell_q;
   assign async_advance_flag = flag_q;
   assign async_schedule_enable = aen_q;
   assign async_list_fetch_enable = fetch_q;
   assign core_light_reset = lr_q == ehci_cmd_pkg::LR_BUSY;
   assign interrupt_threshold_field = thr_q;
endmodule : ehci_command_control

// ===== sim/ehci_command_control_assertions.sv
// Concurrent checks on the command register block ports
`timescale 1ns/1ps
module cmd_chk (
   input wire logic clk, // Clock
   input wire logic reset, // Async reset
   input wire logic [7:0] addr, // Offset
   input wire logic wr_en, // Write strobe
   input wire logic [3:0] byte_en, // Lanes
   input wire logic [31:0] wdata, // Write data
   input wire logic rd_en, // Read strobe
   input wire logic [31:0] rdata, // Read data
   input wire logic controller_halted_flag, // Halted
   input wire logic cache_evicted, // Eviction
   input wire logic async_advance_doorbell, // Bell
   input wire logic async_advance_flag, // Flag
   input wire logic async_schedule_enable, // Enable
   input wire logic async_list_fetch_enable, // Fetch
   input wire logic core_light_reset, // Light reset
   input wire logic [7:0] interrupt_threshold_field, // Threshold
   input wire logic irq_issue // Interrupt
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // Accepted command write; light reset blocks writes
   wire logic cw = wr_en && addr == 8'h20 && !core_light_reset;
   // A ring in the eviction cycle keeps the doorbell up, so it is left out here
   sequence s_ring;
      async_advance_doorbell && cache_evicted && !core_light_reset && !(cw && byte_en[0] && wdata[6]);
   endsequence
   sequence s_adv; async_advance_flag && !async_advance_doorbell; endsequence
   a_flag_on_evict: assert property (s_ring |=> s_adv)
      else $error("flag not set on eviction");
   a_flag_cause: assert property ($rose(async_advance_flag) |-> $past(async_advance_doorbell) && $past(cache_evicted))
      else $error("flag set without bell");
   a_bell_ring: assert property (cw && byte_en[0] && wdata[6] && !wdata[7] |=> async_advance_doorbell)
      else $error("bell not rung");
   a_ase_write: assert property (cw && byte_en[0] && !wdata[7] |=> async_schedule_enable == $past(wdata[5]))
      else $error("enable not written");
   a_thr_write: assert property (cw && byte_en[2] && !(byte_en[0] && wdata[7])
      |=> interrupt_threshold_field == $past(wdata[23:16]))
      else $error("threshold not written");
   a_fetch_gate: assert property (1'b1 |=> async_list_fetch_enable ==
      $past(async_schedule_enable && !controller_halted_flag && !core_light_reset))
      else $error("fetch enable wrong");
   a_lr_start: assert property (cw && byte_en[0] && wdata[7] |=> core_light_reset)
      else $error("light reset not started");
   a_lr_defaults: assert property ($rose(core_light_reset) |=> interrupt_threshold_field == 8'h08
      && !async_schedule_enable && !async_advance_flag && !async_advance_doorbell)
      else $error("light reset left fields");
   a_lr_busy: assert property (rd_en && addr == 8'h20 && core_light_reset |=> rdata[7])
      else $error("busy bit low");
   a_lr_done: assert property (rd_en && addr == 8'h20 && !core_light_reset |=> !rdata[7])
      else $error("busy bit high");
   a_irq_pulse: assert property (irq_issue |=> !irq_issue [*4])
      else $error("interrupts too close");
endmodule : cmd_chk
bind ehci_command_control cmd_chk i_chk (.clk, .reset, .addr, .wr_en, .byte_en, .wdata, .rd_en, .rdata,
   .controller_halted_flag, .cache_evicted, .async_advance_doorbell, .async_advance_flag, .async_schedule_enable,
   .async_list_fetch_enable, .core_light_reset, .interrupt_threshold_field, .irq_issue);

// ===== sim/test_ehci_command_control.sv
// Self-checking bench for the command register block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((e) !== (g)) begin error_cnt++; \
   $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module test_ehci_command_control;
   logic clk = 0, reset = 1, wr_en = 0, rd_en = 0, halted = 1, evict = 0, fclr = 0, irq_en = 0, oth = 0, lr_done = 0;
   logic [7:0] addr = 0, thr = 8'h08, a, thr_o;
   logic [3:0] byte_en = 0, be;
   logic [31:0] wdata = 0, rdata, d;
   logic rd_valid, bell, flag, aen, aen_m = 0, fetch, clr, irq;
   int error_cnt = 0, tests_run = 0, seed = 99277, n;
   logic [7:0] codes [7] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40};
   ehci_command_control #(.MF_CYCLES(8)) i_ehci_command_control (.clk(clk), .reset(reset), .addr(addr),
      .wr_en(wr_en), .byte_en(byte_en), .wdata(wdata), .rd_en(rd_en), .rdata(rdata), .rd_valid(rd_valid),
      .controller_halted_flag(halted), .cache_evicted(evict), .async_advance_flag_clear(fclr),
      .async_advance_irq_enable(irq_en), .other_irq_event(oth), .light_reset_done(lr_done),
      .async_advance_doorbell(bell), .async_advance_flag(flag), .async_schedule_enable(aen),
      .async_list_fetch_enable(fetch), .core_light_reset(clr), .interrupt_threshold_field(thr_o), .irq_issue(irq));
   always #5 clk = ~clk;
   // Interval in cycles, eight per microframe in this bench
   function int exp_gap(logic [7:0] c);
      return int'(c) * 8;
   endfunction : exp_gap
   function logic [31:0] exp_reg(logic [7:0] t, logic e);
      return {8'h00, t, 10'h000, e, 5'h00};
   endfunction : exp_reg
   task wr(input logic [7:0] ad, input logic [3:0] b, input logic [31:0] v);
      @(negedge clk) addr = ad;
      byte_en = b;
      wdata = v;
      wr_en = 1;
      @(negedge clk) wr_en = 0;
   endtask : wr
   task rd(input logic [7:0] ad, output logic [31:0] v);
      @(negedge clk) addr = ad;
      rd_en = 1;
      @(negedge clk) rd_en = 0;
      v = rdata;
      `CHK("read valid", 1'b1, rd_valid)
   endtask : rd
   // Cycles until the next interrupt pulse, bounded
   task wirq(input int lim);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (irq !== 1'b1 && n < lim);
   endtask : wirq
   task stop_test;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : stop_test
   // Watchdog, far beyond the expected few thousand cycles
   initial begin
      #500_000;
      error_cnt++;
      stop_test;
   end
   initial begin
      repeat (3) @(negedge clk);
      reset = 0;
      rd(8'h20, d);
      `CHK("reset value", 32'h0008_0000, d)
      $display("reset test done");
      // Events held high; second gap is a clean interval
      oth = 1;
      foreach (codes[i]) begin
         wr(8'h20, 4'h4, {8'h00, codes[i], 16'h0000});
         wirq(1000);
         wirq(1000);
         `CHK("irq gap", exp_gap(codes[i]), n)
      end
      oth = 0;
      wr(8'h20, 4'h4, 32'h0001_0000);
      wirq(20);
      wirq(20);
      `CHK("idle irq", 1'b0, irq)
      $display("threshold test done");
      // Schedule running before any doorbell, as software must arrange
      halted = 0;
      wr(8'h20, 4'h1, 32'h0000_0020);
      @(negedge clk);
      `CHK("fetch enable", 1'b1, fetch)
      for (int en = 1; en >= 0; en--) begin
         irq_en = en[0];
         wr(8'h20, 4'h1, 32'h0000_0060);
         `CHK("bell", 1'b1, bell)
         repeat (1 + $unsigned($random(seed)) % 4) @(negedge clk);
         evict = 1;
         @(negedge clk) evict = 0;
         `CHK("flag and bell", 2'b10, {flag, bell})
         // The pulse may already stand when the flag set fell on a boundary
         if (irq !== 1'b1) wirq(10);
         `CHK("advance irq", en[0], irq)
         fclr = 1;
         @(negedge clk) fclr = 0;
         evict = 1;
         @(negedge clk) evict = 0;
         `CHK("stray flag", 1'b0, flag)
      end
      halted = 1;
      @(negedge clk);
      `CHK("fetch halted", 1'b0, fetch)
      $display("doorbell test done");
      wr(8'h20, 4'h5, 32'h0040_00a0);
      rd(8'h20, d);
      `CHK("busy bit", 1'b1, d[7])
      `CHK("light reset fields", 12'h081, {thr_o, aen, bell, flag, clr})
      repeat (3 + $unsigned($random(seed)) % 5) @(negedge clk);
      lr_done = 1;
      @(negedge clk) lr_done = 0;
      rd(8'h20, d);
      `CHK("done bit", 2'b00, {d[7], clr})
      $display("light reset test done");
      // Random traffic; threshold lane only written while halted
      for (int i = 0; i < 40; i++) begin
         halted = 1'($random(seed));
         irq_en = 1'($random(seed));
         a = ($random(seed) & 1) ? 8'h20 : 8'($random(seed));
         be = 4'($random(seed));
         d = $random(seed) & 32'hffff_ff3f;
         // Only valid threshold codes; any other value has undefined results
         d[23:16] = codes[$unsigned($random(seed)) % 7];
         if (!halted) be[2] = 0;
         wr(a, be, d);
         if (a == 8'h20 && be[2]) thr = d[23:16];
         if (a == 8'h20 && be[0]) aen_m = d[5];
         rd(8'h20, d);
         `CHK("command reg", exp_reg(thr, aen_m), d)
         rd(a | 8'h01, d);
         `CHK("other offset", 32'h0000_0000, d)
      end
      $display("random test done");
      stop_test;
   end
endmodule : test_ehci_command_control
